// ==== smc_pkg.sv ====
// Shared constants and types of the standby mode controller
package smc_pkg;

    // ********************************************************
    // Bus and register map
    // ********************************************************
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  OFS_MODESEL  = 8'h00;
    localparam logic [7:0]  OFS_PWRCTL   = 8'h04;
    localparam logic [7:0]  OFS_STABSEL  = 8'h08;
    localparam logic [7:0]  OFS_CPUCLK   = 8'h0C;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int          FLAVOUR_POS  = 0;
    localparam int          SUBSTOP_POS  = 7;
    localparam int          STOPREQ_POS  = 1;
    localparam int          IRQ_MASK_POS = 4;
    localparam int          PIN_MASK_POS = 5;
    localparam int          WDT_MASK_POS = 6;
    localparam int          STABSEL_LSB  = 0;
    localparam int          STABSEL_W    = 3;
    localparam int          DIV_LSB      = 0;
    localparam int          SUBSEL_POS   = 3;
    localparam int          STAT_MODE    = 0;
    localparam int          STAT_SUBIDLE = 4;
    localparam int          STAT_STABOK  = 5;

    // ********************************************************
    // Reset values and stabilization counting
    // ********************************************************
    localparam logic [2:0]  STABSEL_RST  = 3'h1;
    localparam logic [2:0]  STABSEL_MAX  = 3'h4;
    localparam logic [2:0]  DIV_RESET    = 3'h3;
    localparam int          STAB_BASE_LOG2 = 14;
    localparam int          CNT_W        = 19;
    localparam int          LOG2_W       = 5;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        SMC_RUN,
        SMC_HALT,
        SMC_IDLE,
        SMC_STOP,
        SMC_STAB
    } smc_mode_t;

    // Release sources, also the layout of the mask group
    typedef struct packed {
        logic wdt_nmi;
        logic pin_nmi;
        logic maskable;
    } smc_wake_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             active;
        logic             done;
    } smc_cnt_state_t;

    typedef struct packed {
        smc_mode_t        mode;
        logic             flavour;
        logic             substop;
        logic             stop_req;
        smc_wake_t        mask;
        logic [2:0]       stabsel;
        logic             subsel;
        logic [2:0]       div;
        logic [31:0]      prdata;
        logic             cpu_en;
        logic             periph_en;
        logic             main_en;
        logic             boot;
        logic             stab_wr;
    } smc_state_t;

endpackage : smc_pkg

// ==== smc_stab_counter.sv ====
// Oscillation stabilization counter driven by main oscillator ticks
`timescale 1ns/1ns
module smc_stab_counter (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      start,
    input  wire logic                      osc_tick,
    input  wire logic                      osc_running,
    input  wire logic [smc_pkg::LOG2_W-1:0] target_log2,
    output logic                           done
);
    import smc_pkg::*;

    smc_cnt_state_t s_q;
    smc_cnt_state_t s_d;
    logic [CNT_W-1:0] last;

    // Last count value of the selected wait, 2^n - 1
    assign last = CNT_W'((CNT_W+1)'(1) << target_log2) - CNT_W'(1);

    // Ticks before the oscillator runs are not counted
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.cnt    = '0;
            s_d.active = 1'b1;
            s_d.done   = 1'b0;
        end else if (s_q.active && osc_running && osc_tick) begin
            if (s_q.cnt == last) begin
                s_d.active = 1'b0;
                s_d.done   = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
    end

    // Wait is armed at reset so reset release also waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{cnt: '0, active: 1'b1, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;

    property p_no_count_idle_osc;
        @(posedge pclk) disable iff (!presetn)
        (s_q.active && !start && !osc_running) |=> $stable(s_q.cnt);
    endproperty
    a_no_count_idle_osc: assert property (p_no_count_idle_osc)
        else $error("stab count moved while oscillator stopped");

    property p_done_exact;
        @(posedge pclk) disable iff (!presetn)
        $rose(s_q.done) |-> $past(s_q.cnt) == last && $past(osc_tick);
    endproperty
    a_done_exact: assert property (p_done_exact)
        else $error("stab done before selected count");

endmodule : smc_stab_counter

// ==== smc_standby_ctrl.sv ====
// Standby mode controller: APB registers, mode sequencing, clock gating
`timescale 1ns/1ns
module smc_standby_ctrl #(
    parameter int STAB_BASE_LOG2 = smc_pkg::STAB_BASE_LOG2
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [smc_pkg::ADDR_W-1:0] paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [smc_pkg::DATA_W-1:0] pwdata,
    output logic      [smc_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      halt_exec,
    input  wire smc_pkg::smc_wake_t        wake_req,
    input  wire logic                      osc_tick,
    input  wire logic                      osc_running,
    output logic                           cpu_clk_en,
    output logic                           periph_clk_en,
    output logic                           main_osc_en,
    output logic                           sub_osc_en,
    output logic                           subclock_sel,
    output logic      [2:0]                cpu_divider,
    output smc_pkg::smc_mode_t             standby_mode
);
    import smc_pkg::*;

    // ********************************************************
    // State and decode
    // ********************************************************
    smc_state_t s_q;
    smc_state_t s_d;

    logic              setup;
    logic              access;
    logic              wr_en;
    logic              mapped;
    logic              wr_modesel;
    logic              wr_pwrctl;
    logic              wr_stabsel;
    logic              wr_cpuclk;
    logic              stop_write;
    logic              release_ok;
    logic              stab_start;
    logic              stab_done;
    logic [2:0]        stabsel_clip;
    logic [LOG2_W-1:0] stab_log2;
    logic [31:0]       rd_word;

    // APB phases; the slave never inserts wait states
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign wr_en  = access && pwrite;

    // Address decode of the five words
    always_comb begin
        mapped = 1'b1;
        if (paddr == OFS_MODESEL) begin
            mapped = 1'b1;
        end else if (paddr == OFS_PWRCTL) begin
            mapped = 1'b1;
        end else if (paddr == OFS_STABSEL) begin
            mapped = 1'b1;
        end else if (paddr == OFS_CPUCLK) begin
            mapped = 1'b1;
        end else if (paddr == OFS_STATUS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Unmapped words and status writes answer with an error
    assign pslverr = access && (!mapped || (pwrite && paddr == OFS_STATUS));

    assign wr_modesel = wr_en && paddr == OFS_MODESEL;
    assign wr_pwrctl  = wr_en && paddr == OFS_PWRCTL;
    assign wr_stabsel = wr_en && paddr == OFS_STABSEL;
    assign wr_cpuclk  = wr_en && paddr == OFS_CPUCLK;

    // A standby request is only a write with the stop bit set
    assign stop_write = wr_pwrctl && pwdata[STOPREQ_POS];

    // Release needs a source whose mask bit is clear
    assign release_ok = |(wake_req & ~s_q.mask);

    // Leaving STOP always arms the wait, whatever feeds the main
    // clock pin: there is no bypass for an external clock
    assign stab_start = s_q.mode == SMC_STOP && release_ok;

    // Settings above the longest wait clip to it
    assign stabsel_clip = (s_q.stabsel > STABSEL_MAX) ? STABSEL_MAX
                                                      : s_q.stabsel;
    assign stab_log2 = LOG2_W'(STAB_BASE_LOG2) + LOG2_W'(stabsel_clip);

    // ********************************************************
    // Stabilization counter
    // ********************************************************
    smc_stab_counter i_smc_stab_counter (
        .pclk        (pclk),
        .presetn     (presetn),
        .start       (stab_start),
        .osc_tick    (osc_tick),
        .osc_running (osc_running),
        .target_log2 (stab_log2),
        .done        (stab_done)
    );

    // ********************************************************
    // Read data
    // ********************************************************
    // Reserved bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == OFS_MODESEL) begin
            rd_word[FLAVOUR_POS] = s_q.flavour;
            rd_word[SUBSTOP_POS] = s_q.substop;
        end else if (paddr == OFS_PWRCTL) begin
            rd_word[STOPREQ_POS]  = s_q.stop_req;
            rd_word[IRQ_MASK_POS] = s_q.mask.maskable;
            rd_word[PIN_MASK_POS] = s_q.mask.pin_nmi;
            rd_word[WDT_MASK_POS] = s_q.mask.wdt_nmi;
        end else if (paddr == OFS_STABSEL) begin
            rd_word[STABSEL_LSB +: STABSEL_W] = s_q.stabsel;
        end else if (paddr == OFS_CPUCLK) begin
            rd_word[DIV_LSB +: 3] = s_q.div;
            rd_word[SUBSEL_POS]   = s_q.subsel;
        end else if (paddr == OFS_STATUS) begin
            rd_word[STAT_MODE +: 3] = s_q.mode;
            rd_word[STAT_SUBIDLE]   = s_q.mode == SMC_IDLE && s_q.subsel;
            rd_word[STAT_STABOK]    = stab_done;
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        s_d = s_q;

        // Read word is captured in setup so prdata is a flop
        if (setup && !pwrite) begin
            s_d.prdata = rd_word;
        end

        // Reserved bits are simply not stored
        if (wr_modesel) begin
            s_d.flavour = pwdata[FLAVOUR_POS];
            s_d.substop = pwdata[SUBSTOP_POS];
        end
        if (wr_stabsel) begin
            s_d.stabsel = pwdata[STABSEL_LSB +: STABSEL_W];
            s_d.stab_wr = 1'b1;
        end
        if (wr_cpuclk) begin
            s_d.div    = pwdata[DIV_LSB +: 3];
            s_d.subsel = pwdata[SUBSEL_POS];
        end
        // Masks written together with the stop bit are ignored, so
        // software must set masks in an earlier store
        if (wr_pwrctl && !pwdata[STOPREQ_POS]) begin
            s_d.mask.maskable = pwdata[IRQ_MASK_POS];
            s_d.mask.pin_nmi  = pwdata[PIN_MASK_POS];
            s_d.mask.wdt_nmi  = pwdata[WDT_MASK_POS];
        end

        // Mode sequencing
        case (s_q.mode)
            SMC_RUN: begin
                if (stop_write) begin
                    // Flavour bit acts here and nowhere else
                    s_d.stop_req = 1'b1;
                    s_d.mode = s_q.flavour ? SMC_STOP : SMC_IDLE;
                end else if (halt_exec) begin
                    // Entered even with a request pending, unless a stop write comes in the same cycle
                    s_d.mode = SMC_HALT;
                end
            end
            SMC_HALT: begin
                // Any request the core sees ends HALT
                if (|wake_req) begin
                    s_d.mode = SMC_RUN;
                end
            end
            SMC_IDLE: begin
                if (release_ok) begin
                    s_d.stop_req = 1'b0;
                    s_d.mode     = SMC_RUN;
                end
            end
            SMC_STOP: begin
                if (release_ok) begin
                    s_d.stop_req = 1'b0;
                    s_d.mode     = SMC_STAB;
                end
            end
            SMC_STAB: begin
                // CPU waits for the counter, not for a fixed time
                if (stab_done) begin
                    s_d.mode = SMC_RUN;
                    s_d.boot = 1'b0;
                end
            end
            default: begin
                s_d.mode = SMC_RUN;
            end
        endcase

        // Clock enables follow the next mode so they are flops
        s_d.cpu_en    = s_d.mode == SMC_RUN;
        s_d.periph_en = s_d.mode == SMC_RUN || s_d.mode == SMC_HALT;
        s_d.main_en   = s_d.mode != SMC_STOP;
    end

    // ********************************************************
    // State register
    // ********************************************************
    // Reset lands in the wait state with the counter armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{mode:      SMC_STAB,
                     flavour:   1'b0,
                     substop:   1'b0,
                     stop_req:  1'b0,
                     mask:      '0,
                     stabsel:   STABSEL_RST,
                     subsel:    1'b0,
                     div:       DIV_RESET,
                     prdata:    32'h0000_0000,
                     cpu_en:    1'b0,
                     periph_en: 1'b0,
                     main_en:   1'b1,
                     boot:      1'b1,
                     stab_wr:   1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign prdata        = s_q.prdata;
    assign cpu_clk_en    = s_q.cpu_en;
    assign periph_clk_en = s_q.periph_en;
    assign main_osc_en   = s_q.main_en;
    assign sub_osc_en    = !s_q.substop;
    assign subclock_sel  = s_q.subsel;
    assign cpu_divider   = s_q.div;
    assign standby_mode  = s_q.mode;

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_no_req_no_standby;
        @(posedge pclk) disable iff (!presetn)
        (s_q.mode == SMC_RUN && wr_pwrctl && !pwdata[STOPREQ_POS])
            |=> s_q.mode inside {SMC_RUN, SMC_HALT};
    endproperty
    a_no_req_no_standby: assert property (p_no_req_no_standby)
        else $error("standby entered without stop request");

    property p_flavour_stop;
        @(posedge pclk) disable iff (!presetn)
        (s_q.mode == SMC_RUN && stop_write && s_q.flavour)
            |=> s_q.mode == SMC_STOP && !cpu_clk_en;
    endproperty
    a_flavour_stop: assert property (p_flavour_stop)
        else $error("stop request with flavour one did not reach STOP");

    property p_boot_stabsel;
        @(posedge pclk) disable iff (!presetn)
        (s_q.boot && !s_q.stab_wr)
            |-> stab_log2 == LOG2_W'(STAB_BASE_LOG2 + 1);
    endproperty
    a_boot_stabsel: assert property (p_boot_stabsel)
        else $error("reset wait is not the 01H selection");

    property p_stop_goes_stab;
        @(posedge pclk) disable iff (!presetn)
        (s_q.mode == SMC_STOP && release_ok)
            |=> s_q.mode == SMC_STAB ##1 !cpu_clk_en;
    endproperty
    a_stop_goes_stab: assert property (p_stop_goes_stab)
        else $error("STOP release skipped stabilization wait");

    sequence s_halt_then_run;
        s_q.mode == SMC_HALT ##1 s_q.mode == SMC_RUN;
    endsequence

    property p_halt_pending;
        @(posedge pclk) disable iff (!presetn)
        (s_q.mode == SMC_RUN && halt_exec && !stop_write && (|wake_req)
            ##1 (|wake_req)) |-> s_halt_then_run;
    endproperty
    a_halt_pending: assert property (p_halt_pending)
        else $error("HALT with pending request not entered then left");

    property p_masked_holds;
        @(posedge pclk) disable iff (!presetn)
        (s_q.mode inside {SMC_IDLE, SMC_STOP} && !release_ok)
            |=> $stable(s_q.mode) && !cpu_clk_en;
    endproperty
    a_masked_holds: assert property (p_masked_holds)
        else $error("masked source released standby");

    property p_stab_gated;
        @(posedge pclk) disable iff (!presetn)
        (s_q.mode == SMC_STAB && !stab_done) |=> !cpu_clk_en;
    endproperty
    a_stab_gated: assert property (p_stab_gated)
        else $error("CPU clock ungated before stabilization done");

endmodule : smc_standby_ctrl

// ==== smc_standby_ctrl_bench.sv ====
// Self-checking bench of the standby mode controller
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module smc_standby_ctrl_bench;
    import smc_pkg::*;

    // ****************************************************************
    // Signals and instance
    // ****************************************************************
    logic              pclk;
    logic              presetn;
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              halt_exec;
    smc_wake_t         wake_req;
    logic              osc_tick;
    logic              osc_running;
    logic              cpu_clk_en;
    logic              periph_clk_en;
    logic              main_osc_en;
    logic              sub_osc_en;
    logic              subclock_sel;
    logic [2:0]        cpu_divider;
    smc_mode_t         standby_mode;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                bad_count;
    int                check_count;

    // Short base exponent keeps every stabilization wait at 64 ticks or fewer
    smc_standby_ctrl #(.STAB_BASE_LOG2(2)) i_smc_standby_ctrl (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_exec(halt_exec), .wake_req(wake_req), .osc_tick(osc_tick),
        .osc_running(osc_running), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .main_osc_en(main_osc_en),
        .sub_osc_en(sub_osc_en), .subclock_sel(subclock_sel),
        .cpu_divider(cpu_divider), .standby_mode(standby_mode)
    );

    // ****************************************************************
    // Clock and watchdog
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Whole run is a few hundred cycles; this only catches a hang
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    // ****************************************************************
    // Bus and stimulus tasks
    // ****************************************************************
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    // Oscillator period pulses, counted only while running is high
    task automatic ticks(input int n, input logic run);
        osc_running <= run;
        repeat (n) begin
            @(posedge pclk);
            osc_tick <= 1'b1;
            @(posedge pclk);
            osc_tick <= 1'b0;
        end
    endtask : ticks

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        bad_count = 0;
        check_count = 0;
        presetn = 1'b0;
        {paddr, psel, penable, pwrite, pwdata} = '0;
        {halt_exec, osc_tick, osc_running} = '0;
        wake_req = '0;
        settle(4);
        `CHK("rst mode", SMC_STAB, standby_mode)
        `CHK("rst cpu", 1'b0, cpu_clk_en)
        `CHK("rst main", 1'b1, main_osc_en)
        `CHK("rst sub", 1'b1, sub_osc_en)
        `CHK("rst div", 3'h3, cpu_divider)
        `CHK("rst ssel", 1'b0, subclock_sel)
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset wait is 2^(2+1) = 8 running ticks
        apb(1'b0, OFS_STABSEL, '0);
        `CHK("stabsel rst", 32'h0000_0001, rd)
        ticks(10, 1'b0);
        ticks(7, 1'b1);
        settle(6);
        `CHK("rst wait", SMC_STAB, standby_mode)
        `CHK("rst gate", 1'b0, cpu_clk_en)
        ticks(1, 1'b1);
        settle(6);
        `CHK("rst run", SMC_RUN, standby_mode)
        `CHK("rst ungate", 1'b1, cpu_clk_en)
        // Reset values and reserved bits of the map
        apb(1'b0, OFS_CPUCLK, '0);
        `CHK("cpuclk rst", 32'h0000_0003, rd)
        apb(1'b0, OFS_PWRCTL, '0);
        `CHK("pwrctl rst", 32'h0000_0000, rd)
        // Upper bits written as zero, as software must keep them
        apb(1'b1, OFS_STABSEL, 32'h0000_0007);
        apb(1'b0, OFS_STABSEL, '0);
        `CHK("stabsel rw", 32'h0000_0007, rd)
        apb(1'b1, 8'h14, 32'h0000_0001);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_STATUS, 32'h0000_0001);
        `CHK("status ro", 1'b1, err)
        // No resonator is fitted here, so the subclock may be stopped
        apb(1'b1, OFS_MODESEL, 32'h0000_0080);
        settle(1);
        `CHK("substop", 1'b0, sub_osc_en)
        // Flavour select alone, or with no stop bit, does not leave RUN
        apb(1'b1, OFS_MODESEL, 32'h0000_0001);
        apb(1'b1, OFS_PWRCTL, 32'h0000_0060);
        settle(3);
        `CHK("no req", SMC_RUN, standby_mode)
        `CHK("substop off", 1'b1, sub_osc_en)
        // STOP with two sources masked; selection 6 clips to 2^(2+4)
        apb(1'b1, OFS_STABSEL, 32'h0000_0006);
        apb(1'b1, OFS_PWRCTL, 32'h0000_0002);
        // Idle cycles stand in for the NOPs after a standby store
        settle(2);
        `CHK("stop", SMC_STOP, standby_mode)
        `CHK("stop osc", 1'b0, main_osc_en)
        `CHK("stop cpu", 1'b0, cpu_clk_en)
        wake_req <= 3'b110;
        settle(4);
        `CHK("stop masked", SMC_STOP, standby_mode)
        wake_req <= 3'b111;
        settle(2);
        `CHK("stop rel", SMC_STAB, standby_mode)
        wake_req <= 3'b000;
        ticks(3, 1'b0);
        ticks(63, 1'b1);
        settle(6);
        `CHK("stab wait", SMC_STAB, standby_mode)
        `CHK("stab gate", 1'b0, cpu_clk_en)
        ticks(1, 1'b1);
        settle(6);
        `CHK("stab run", SMC_RUN, standby_mode)
        `CHK("stab cpu", 1'b1, cpu_clk_en)
        // Sub-IDLE: subclock selected, maskable source masked
        apb(1'b1, OFS_PWRCTL, 32'h0000_0010);
        apb(1'b1, OFS_MODESEL, 32'h0000_0000);
        // Divider 3 is taken as fast enough against the subclock
        apb(1'b1, OFS_CPUCLK, 32'h0000_000B);
        settle(1);
        `CHK("subsel", 1'b1, subclock_sel)
        `CHK("div kept", 3'h3, cpu_divider)
        apb(1'b1, OFS_PWRCTL, 32'h0000_0002);
        apb(1'b0, OFS_STATUS, '0);
        `CHK("subidle", 5'h12, rd[4:0])
        wake_req <= 3'b001;
        settle(4);
        `CHK("idle masked", SMC_IDLE, standby_mode)
        `CHK("idle periph", 1'b0, periph_clk_en)
        wake_req <= 3'b011;
        settle(2);
        `CHK("idle rel", SMC_RUN, standby_mode)
        apb(1'b1, OFS_CPUCLK, 32'h0000_0003);
        // HALT taken with a request already pending
        wake_req <= 3'b001;
        @(posedge pclk);
        halt_exec <= 1'b1;
        @(posedge pclk);
        halt_exec <= 1'b0;
        #1;
        `CHK("halt in", SMC_HALT, standby_mode)
        settle(1);
        `CHK("halt out", SMC_RUN, standby_mode)
        wake_req <= 3'b000;
        settle(2);
        print_verdict();
    end
endmodule : smc_standby_ctrl_bench
